// ---- rtl/dles_pkg.sv ----
package dles_pkg;

	// reference clock and the millisecond tick of the receive timeout
	localparam int unsigned REF_CLK_HZ = 40_000_000;
	localparam int unsigned MS_PERIOD_US = 1000;
	localparam int unsigned MS_TICK_CYCLES = REF_CLK_HZ / 1_000_000 * MS_PERIOD_US;

	// apb address width; byte address = 4 * register index
	localparam int unsigned APB_AW = 8;

	// register indices
	localparam logic [7:0] IDX_TIMEOUT = 8'h08;
	localparam logic [7:0] IDX_STATUS = 8'h0F;
	localparam logic [7:0] IDX_LANE3 = 8'h13;
	localparam logic [7:0] IDX_CLK_LANE = 8'h14;
	localparam logic [7:0] IDX_SNAPSHOT = 8'h15;
	localparam logic [7:0] IDX_LANE_ENABLE = 8'h30;

	// lane 3 error flag positions
	localparam int unsigned L3_END_SYNC_BIT = 4;
	localparam int unsigned L3_START_BIT_BIT = 3;
	localparam int unsigned L3_START_PATTERN_BIT = 2;
	localparam int unsigned L3_FAST_REQ_CTL_BIT = 1;
	localparam int unsigned L3_TIMEOUT_BIT = 0;

	// clock lane error flag positions
	localparam int unsigned CLK_SLEEP_REQ_CTL_BIT = 3;
	localparam int unsigned CLK_FAST_REQ_CTL_BIT = 2;
	localparam int unsigned CLK_BAD_SLEEP_BIT = 1;
	localparam int unsigned CLK_TIMEOUT_BIT = 0;

	// status register positions
	localparam int unsigned STS_SYNC_ERR_BIT = 6;
	localparam int unsigned STS_ANY_FAULT_BIT = 5;

	// reset values
	localparam logic [7:0] TIMEOUT_RST = 8'h00;
	localparam logic [3:0] LANE_ENABLE_RST = 4'hF;
	localparam logic [4:0] LANE3_FLAGS_RST = 5'h00;
	localparam logic [3:0] CLK_FLAGS_RST = 4'h0;
	localparam logic [3:0] SNAPSHOT_RST = 4'h0;

	typedef enum logic {APB_IDLE, APB_ANSWER} dles_apb_state_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [APB_AW-1:0] paddr;
		logic [31:0] pwdata;
	} dles_apb_req_t;

	typedef struct packed {
		logic end_sync;
		logic start_bit;
		logic start_pattern;
		logic fast_request_ctl;
	} dles_lane3_evt_t;

	typedef struct packed {
		logic sleep_request_ctl;
		logic fast_request_ctl;
		logic bad_sleep_state;
	} dles_clk_evt_t;

endpackage

// ---- rtl/dles_lane_error_status.sv ----
`timescale 1ns/100ps
// Summary of operation
// - lane 3 end-sync fault, bit 4, read-clear
// - lane 3 start bit fault, bit 3, read-clear
// - lane 3 start pattern fault, bit 2, read-clear
// - lane 3 request control fault, bit 1, read-clear
// - receive timeouts in bit 0, both lanes
// - clock lane control faults, bits 3 and 2
// - clock lane bad sleep state, bit 1
// - per-lane sync snapshot, read only, bits 3-0
// - enabled lanes must sync together, else flag
// - summary bit 5 set while any lane 3 or clock lane flag, not the sync error
// - timeout in milliseconds, zero disables it
module dles_lane_error_status
	import dles_pkg::*;
#(
	parameter int unsigned MS_CYCLES = MS_TICK_CYCLES
) (
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire dles_apb_req_t i_apb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_link_clk,
	input wire dles_lane3_evt_t i_lane3_evt,
	input wire dles_clk_evt_t i_clk_evt,
	input wire logic [3:0] i_sync_det,
	input wire logic i_lane3_hs_active,
	input wire logic i_clk_hs_active
);

	// below two cycles the tick counter would have no bits at all
	if (MS_CYCLES < 2) begin : g_ms_check
		$error("MS_CYCLES must be at least 2");
	end

	function automatic logic addr_hit(input logic [APB_AW-1:0] addr, input logic [7:0] idx);
		addr_hit = (addr[1:0] == 2'b00) && (addr[APB_AW-1:2] == idx[APB_AW-3:0]);
	endfunction

	// ---------------- link clock domain ----------------
	logic [3:0] lane_en_meta_reg;
	logic [3:0] lane_en_link_reg;
	logic [3:0] lane_enable_reg;
	logic [3:0] det_en;
	logic link_sync_err;
	logic [7:0] link_evt;
	logic [7:0] evt_tgl_reg;
	logic [3:0] snap_link_reg;

	// limitation: enable crosses bit by bit, so change it only while the lanes are idle
	always_ff @(posedge i_link_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			lane_en_meta_reg <= LANE_ENABLE_RST;
			lane_en_link_reg <= LANE_ENABLE_RST;
		end else begin
			lane_en_meta_reg <= lane_enable_reg;
			lane_en_link_reg <= lane_en_meta_reg;
		end
	end

	assign det_en = i_sync_det & lane_en_link_reg;
	// some but not all enabled lanes saw the sync sequence this cycle
	assign link_sync_err = (|det_en) && (det_en != lane_en_link_reg);
	assign link_evt = {link_sync_err, i_clk_evt, i_lane3_evt};

	// each event flips its own toggle; a level crosses safely where a pulse would not
	always_ff @(posedge i_link_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			evt_tgl_reg <= 8'h00;
		end else begin
			evt_tgl_reg <= evt_tgl_reg ^ link_evt;
		end
	end

	// held until the next sync error, so the reference side may read it after the toggle lands
	always_ff @(posedge i_link_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			snap_link_reg <= SNAPSHOT_RST;
		end else if (link_sync_err) begin
			snap_link_reg <= i_sync_det;
		end
	end

	a_link_sync_snap: assert property (@(posedge i_link_clk) disable iff (!i_arst_n)
		link_sync_err |=> (snap_link_reg == $past(i_sync_det)) && (evt_tgl_reg[7] != $past(evt_tgl_reg[7])))
		else $error("sync error not captured on link side");

	// ---------------- reference clock domain ----------------
	logic [7:0] tgl_meta_reg;
	logic [7:0] tgl_sync_reg;
	logic [7:0] tgl_prev_reg;
	logic [7:0] evt_ref;
	logic [1:0] hs_meta_reg;
	logic [1:0] hs_sync_reg;

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			tgl_meta_reg <= 8'h00;
			tgl_sync_reg <= 8'h00;
			tgl_prev_reg <= 8'h00;
			hs_meta_reg <= 2'b00;
			hs_sync_reg <= 2'b00;
		end else begin
			tgl_meta_reg <= evt_tgl_reg;
			tgl_sync_reg <= tgl_meta_reg;
			tgl_prev_reg <= tgl_sync_reg;
			hs_meta_reg <= {i_clk_hs_active, i_lane3_hs_active};
			hs_sync_reg <= hs_meta_reg;
		end
	end

	assign evt_ref = tgl_sync_reg ^ tgl_prev_reg;

	// shared millisecond tick; a lane's first tick may come anywhere inside the first ms
	logic [$clog2(MS_CYCLES)-1:0] ms_cnt_reg;
	logic ms_tick_reg;
	logic [7:0] fast_rx_timeout_ms_reg;
	logic [1:0] tmo_fire;

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ms_cnt_reg <= '0;
			ms_tick_reg <= 1'b0;
		end else if (ms_cnt_reg == ($clog2(MS_CYCLES))'(MS_CYCLES - 1)) begin
			ms_cnt_reg <= '0;
			ms_tick_reg <= 1'b1;
		end else begin
			ms_cnt_reg <= ms_cnt_reg + 1'b1;
			ms_tick_reg <= 1'b0;
		end
	end

	// lane 0 of the loop is data lane 3, lane 1 is the clock lane
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_tmo
			logic [7:0] lane_ms_reg;
			logic fired_reg;
			assign tmo_fire[g] = ms_tick_reg && hs_sync_reg[g] && !fired_reg
				&& (fast_rx_timeout_ms_reg != 8'h00)
				&& ((lane_ms_reg + 8'h01) == fast_rx_timeout_ms_reg);
			always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
				if (!i_arst_n) begin
					lane_ms_reg <= 8'h00;
					fired_reg <= 1'b0;
				end else if (!hs_sync_reg[g] || (fast_rx_timeout_ms_reg == 8'h00)) begin
					lane_ms_reg <= 8'h00;
					fired_reg <= 1'b0;
				end else if (ms_tick_reg && !fired_reg) begin
					lane_ms_reg <= lane_ms_reg + 8'h01;
					fired_reg <= tmo_fire[g];
				end
			end
		end
	endgenerate

	a_timeout_off: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(fast_rx_timeout_ms_reg == 8'h00) |-> (tmo_fire == 2'b00))
		else $error("timeout fired while disabled");

	// ---------------- apb slave ----------------
	dles_apb_state_t apb_state_reg;
	logic apb_take;
	logic apb_done;
	logic [31:0] rdata_next;
	logic slverr_next;
	logic rd_lane3;
	logic rd_clk;
	logic rd_status;
	logic [4:0] lane3_flags_reg;
	logic [3:0] clk_flags_reg;
	logic [3:0] snapshot_reg;
	logic sync_err_reg;
	logic any_fault;
	logic [4:0] lane3_set;
	logic [3:0] clk_set;

	// one wait state: data and read side effects are fixed at the first access edge
	assign apb_take = (apb_state_reg == APB_IDLE) && i_apb.psel && i_apb.penable;
	assign apb_done = (apb_state_reg == APB_ANSWER) && i_apb.psel && i_apb.penable;
	assign rd_lane3 = apb_take && !i_apb.pwrite && addr_hit(i_apb.paddr, IDX_LANE3);
	assign rd_clk = apb_take && !i_apb.pwrite && addr_hit(i_apb.paddr, IDX_CLK_LANE);
	assign rd_status = apb_take && !i_apb.pwrite && addr_hit(i_apb.paddr, IDX_STATUS);
	assign any_fault = (|lane3_flags_reg) || (|clk_flags_reg);

	always_comb begin
		rdata_next = 32'h0000_0000;
		slverr_next = 1'b0;
		if (addr_hit(i_apb.paddr, IDX_TIMEOUT)) begin
			rdata_next[7:0] = fast_rx_timeout_ms_reg;
		end else if (addr_hit(i_apb.paddr, IDX_STATUS)) begin
			rdata_next[STS_SYNC_ERR_BIT] = sync_err_reg;
			rdata_next[STS_ANY_FAULT_BIT] = any_fault;
		end else if (addr_hit(i_apb.paddr, IDX_LANE3)) begin
			rdata_next[4:0] = lane3_flags_reg;
		end else if (addr_hit(i_apb.paddr, IDX_CLK_LANE)) begin
			rdata_next[3:0] = clk_flags_reg;
		end else if (addr_hit(i_apb.paddr, IDX_SNAPSHOT)) begin
			rdata_next[3:0] = snapshot_reg;
		end else if (addr_hit(i_apb.paddr, IDX_LANE_ENABLE)) begin
			rdata_next[3:0] = lane_enable_reg;
		end else begin
			slverr_next = 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			apb_state_reg <= APB_IDLE;
			o_pready <= 1'b0;
			o_prdata <= 32'h0000_0000;
			o_pslverr <= 1'b0;
		end else begin
			case (apb_state_reg)
				APB_IDLE: begin
					if (apb_take) begin
						apb_state_reg <= APB_ANSWER;
						o_pready <= 1'b1;
						o_prdata <= i_apb.pwrite ? 32'h0000_0000 : rdata_next;
						o_pslverr <= slverr_next;
					end
				end
				APB_ANSWER: begin
					apb_state_reg <= APB_IDLE;
					o_pready <= 1'b0;
					o_pslverr <= 1'b0;
				end
				default: begin
					apb_state_reg <= APB_IDLE;
					o_pready <= 1'b0;
				end
			endcase
		end
	end

	// writes take effect at the completing edge; read-only targets ignore them
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			fast_rx_timeout_ms_reg <= TIMEOUT_RST;
			lane_enable_reg <= LANE_ENABLE_RST;
		end else if (apb_done && i_apb.pwrite) begin
			if (addr_hit(i_apb.paddr, IDX_TIMEOUT)) begin
				fast_rx_timeout_ms_reg <= i_apb.pwdata[7:0];
			end else if (addr_hit(i_apb.paddr, IDX_LANE_ENABLE)) begin
				lane_enable_reg <= i_apb.pwdata[3:0];
			end
		end
	end

	// ---------------- error flags ----------------
	assign lane3_set[L3_END_SYNC_BIT] = evt_ref[3];
	assign lane3_set[L3_START_BIT_BIT] = evt_ref[2];
	assign lane3_set[L3_START_PATTERN_BIT] = evt_ref[1];
	assign lane3_set[L3_FAST_REQ_CTL_BIT] = evt_ref[0];
	assign lane3_set[L3_TIMEOUT_BIT] = tmo_fire[0];
	assign clk_set[CLK_SLEEP_REQ_CTL_BIT] = evt_ref[6];
	assign clk_set[CLK_FAST_REQ_CTL_BIT] = evt_ref[5];
	assign clk_set[CLK_BAD_SLEEP_BIT] = evt_ref[4];
	assign clk_set[CLK_TIMEOUT_BIT] = tmo_fire[1];

	// a new event in the clearing cycle survives the read
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			lane3_flags_reg <= LANE3_FLAGS_RST;
		end else begin
			lane3_flags_reg <= (rd_lane3 ? 5'h00 : lane3_flags_reg) | lane3_set;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			clk_flags_reg <= CLK_FLAGS_RST;
		end else begin
			clk_flags_reg <= (rd_clk ? 4'h0 : clk_flags_reg) | clk_set;
		end
	end

	// limitation: two sync errors closer than about three reference cycles may merge
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			snapshot_reg <= SNAPSHOT_RST;
			sync_err_reg <= 1'b0;
		end else begin
			if (evt_ref[7]) begin
				snapshot_reg <= snap_link_reg;
			end
			sync_err_reg <= (rd_status ? 1'b0 : sync_err_reg) | evt_ref[7];
		end
	end

	// ---------------- checks ----------------
	// two clock domains here, so every check names its own clock

	a_end_sync_set: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		lane3_set[L3_END_SYNC_BIT] |=> lane3_flags_reg[L3_END_SYNC_BIT])
		else $error("lane 3 end-sync fault not latched");

	a_start_bit_clear: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(rd_lane3 && !lane3_set[L3_START_BIT_BIT])
		|=> !lane3_flags_reg[L3_START_BIT_BIT])
		else $error("lane 3 start bit fault not cleared by read");

	a_pattern_hold: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(lane3_flags_reg[L3_START_PATTERN_BIT] && !rd_lane3)
		|=> lane3_flags_reg[L3_START_PATTERN_BIT])
		else $error("lane 3 start pattern fault lost without read");

	a_ctl_read_value: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		rd_lane3 |=> o_pready
		&& (o_prdata[L3_FAST_REQ_CTL_BIT] == $past(lane3_flags_reg[L3_FAST_REQ_CTL_BIT])))
		else $error("lane 3 read did not return flag value");

	a_clk_timeout_set: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		tmo_fire[1] |=> clk_flags_reg[CLK_TIMEOUT_BIT])
		else $error("clock lane timeout not latched");

	a_clk_ctl_set: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(clk_set[3:2] != 2'b00)
		|=> ((clk_flags_reg[3:2] & $past(clk_set[3:2])) == $past(clk_set[3:2])))
		else $error("clock lane control fault not latched");

	a_bad_sleep_clear: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(rd_clk && !clk_set[CLK_BAD_SLEEP_BIT])
		|=> !clk_flags_reg[CLK_BAD_SLEEP_BIT])
		else $error("clock lane bad sleep flag not cleared");

	a_snapshot_stable: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		!evt_ref[7] |=> $stable(snapshot_reg))
		else $error("snapshot changed without sync error");

	a_summary_read: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		rd_status |=> o_pready
		&& (o_prdata[STS_ANY_FAULT_BIT] == $past(any_fault)))
		else $error("summary bit wrong on read");

	a_set_wins: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(rd_lane3 && (lane3_set != 5'h00))
		|=> ((lane3_flags_reg & $past(lane3_set)) == $past(lane3_set)))
		else $error("event lost under clearing read");

	a_apb_answer: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		apb_take |=> o_pready ##1 !o_pready)
		else $error("apb answer not one cycle");

	c_lane3_read: cover property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		lane3_flags_reg[L3_END_SYNC_BIT] ##[1:20] rd_lane3);
	c_timeout: cover property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		tmo_fire[0]);
	c_sync_error: cover property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		evt_ref[7] ##[1:20] rd_status);
	c_race: cover property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		rd_clk && (clk_set != 4'h0));

endmodule

// ---- bench/dles_dsi_src.sv ----
`timescale 1ns/100ps
module dles_dsi_src
	import dles_pkg::*;
(
	input wire logic i_link_clk,
	output dles_lane3_evt_t o_lane3_evt,
	output dles_clk_evt_t o_clk_evt,
	output logic [3:0] o_sync_det,
	output logic o_lane3_hs,
	output logic o_clk_hs
);
	initial begin
		o_lane3_evt = '0;
		o_clk_evt = '0;
		o_sync_det = 4'h0;
		o_lane3_hs = 1'b0;
		o_clk_hs = 1'b0;
	end
	// line faults last one link cycle, as the receiver front end reports them
	task automatic fault(input logic [3:0] l3, input logic [2:0] ck);
		@(posedge i_link_clk);
		o_lane3_evt <= dles_lane3_evt_t'(l3);
		o_clk_evt <= dles_clk_evt_t'(ck);
		@(posedge i_link_clk);
		o_lane3_evt <= '0;
		o_clk_evt <= '0;
	endtask
	// lanes drop sync together afterwards, which is never a fault by itself
	task automatic sync(input logic [3:0] det);
		@(posedge i_link_clk);
		o_sync_det <= det;
		@(posedge i_link_clk);
		o_sync_det <= 4'h0;
	endtask
	task automatic hs(input logic l3, input logic ck);
		@(posedge i_link_clk);
		o_lane3_hs <= l3;
		o_clk_hs <= ck;
	endtask
endmodule

// ---- bench/any_lane_fault_summary_status_tb_top.sv ----
`timescale 1ns/100ps
module any_lane_fault_summary_status_tb_top;
	import dles_pkg::*;
	localparam int unsigned MS = 8;
	logic clk = 1'b0;
	logic lclk = 1'b0;
	logic arst_n = 1'b0;
	dles_apb_req_t apb = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	dles_lane3_evt_t l3_evt;
	dles_clk_evt_t ck_evt;
	logic [3:0] sync_det;
	logic l3_hs;
	logic ck_hs;
	int n_mismatch = 0;
	int check_count = 0;

	always #12.5 clk = ~clk;
	// odd start offset keeps the link clock out of phase with the register clock
	initial begin
		#1.7;
		forever #3 lclk = ~lclk;
	end

	dles_lane_error_status #(.MS_CYCLES(MS)) uut (.i_ref_clk(clk), .i_arst_n(arst_n), .i_apb(apb),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_link_clk(lclk),
		.i_lane3_evt(l3_evt), .i_clk_evt(ck_evt), .i_sync_det(sync_det),
		.i_lane3_hs_active(l3_hs), .i_clk_hs_active(ck_hs));
	dles_dsi_src src (.i_link_clk(lclk), .o_lane3_evt(l3_evt), .o_clk_evt(ck_evt),
		.o_sync_det(sync_det), .o_lane3_hs(l3_hs), .o_clk_hs(ck_hs));

	task automatic test_done();
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic apb_xfer(input logic [7:0] idx, input logic wr, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge clk);
		apb.psel <= 1'b1;
		apb.penable <= 1'b0;
		apb.pwrite <= wr;
		apb.paddr <= {idx[5:0], 2'b00};
		apb.pwdata <= wd;
		@(posedge clk);
		apb.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			n_mismatch++;
			$display("unexpected at %0t: no ready", $time);
			test_done();
		end
		rd = prdata;
		err = pslverr;
		apb.psel <= 1'b0;
		apb.penable <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input string what);
		logic [31:0] d;
		logic e;
		apb_xfer(idx, 1'b0, 32'h0, d, e);
		check(d, exp, what);
		check({31'h0, e}, 32'h0, "error flag");
	endtask
	task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
		logic [31:0] d;
		logic e;
		apb_xfer(idx, 1'b1, wd, d, e);
		check({31'h0, e}, 32'h0, "write error");
	endtask

	task automatic t_reset();
		logic [31:0] d;
		logic e;
		rd_chk(IDX_LANE3, 32'h0, "lane3 reset");
		rd_chk(IDX_CLK_LANE, 32'h0, "clk reset");
		rd_chk(IDX_SNAPSHOT, 32'h0, "snapshot reset");
		rd_chk(IDX_STATUS, 32'h0, "status reset");
		rd_chk(IDX_TIMEOUT, 32'h0, "timeout reset");
		rd_chk(IDX_LANE_ENABLE, 32'hF, "enable reset");
		apb_xfer(8'h01, 1'b0, 32'h0, d, e);
		check({d[30:0], e}, 32'h1, "unmapped");
	endtask
	// each fault alone, then all at once, every one behind a write that must be ignored
	task automatic t_flags(input logic [7:0] idx, input int nb, input logic is_clk);
		logic [3:0] v;
		for (int b = 1; b <= nb + 1; b++) begin
			v = (b <= nb) ? 4'(1 << (b - 1)) : 4'(2 ** nb - 1);
			src.fault(is_clk ? 4'h0 : v, is_clk ? v[2:0] : 3'h0);
			repeat (10) @(posedge clk);
			wr(idx, 32'hFF);
			rd_chk(IDX_STATUS, 32'h20, "summary set");
			rd_chk(idx, {27'h0, v, 1'b0}, "flag set");
			rd_chk(idx, 32'h0, "flag cleared");
			rd_chk(IDX_STATUS, 32'h0, "summary cleared");
		end
	endtask
	task automatic t_sync();
		src.sync(4'hF);
		repeat (10) @(posedge clk);
		rd_chk(IDX_STATUS, 32'h0, "aligned sync");
		src.sync(4'h5);
		repeat (10) @(posedge clk);
		rd_chk(IDX_STATUS, 32'h40, "sync error");
		rd_chk(IDX_SNAPSHOT, 32'h5, "snapshot");
		rd_chk(IDX_STATUS, 32'h0, "sync error read");
		wr(IDX_LANE_ENABLE, 32'h7);
		// let the new enable reach the link side before the lanes sync
		repeat (2) @(posedge clk);
		src.sync(4'h7);
		repeat (10) @(posedge clk);
		rd_chk(IDX_STATUS, 32'h0, "disabled lane");
		wr(IDX_SNAPSHOT, 32'hA);
		rd_chk(IDX_SNAPSHOT, 32'h5, "snapshot kept");
		wr(IDX_LANE_ENABLE, 32'hF);
	endtask
	task automatic t_timeout();
		wr(IDX_TIMEOUT, 32'h2);
		rd_chk(IDX_TIMEOUT, 32'h2, "count");
		src.hs(1'b1, 1'b1);
		rd_chk(IDX_LANE3, 32'h0, "too early");
		repeat (MS * 3 + 10) @(posedge clk);
		rd_chk(IDX_LANE3, 32'h1, "lane3 timeout");
		rd_chk(IDX_CLK_LANE, 32'h1, "clk timeout");
		repeat (MS * 3) @(posedge clk);
		rd_chk(IDX_LANE3, 32'h0, "once per burst");
		src.hs(1'b0, 1'b0);
		wr(IDX_TIMEOUT, 32'h0);
		src.hs(1'b1, 1'b1);
		// long enough that a zero count taken as 256 ms would have fired
		repeat (MS * 260) @(posedge clk);
		rd_chk(IDX_LANE3, 32'h0, "disabled lane3");
		rd_chk(IDX_CLK_LANE, 32'h0, "disabled clk");
		src.hs(1'b0, 1'b0);
	endtask
	// a fault landing on the clearing read shows in that read or the next, never in neither
	task automatic t_race();
		logic [31:0] d1;
		logic [31:0] d2;
		logic e;
		for (int k = 0; k < 16; k++) begin
			fork
				src.fault(4'h8, 3'h4);
				begin
					repeat (k / 2) @(posedge clk);
					apb_xfer(k[0] ? IDX_CLK_LANE : IDX_LANE3, 1'b0, 32'h0, d1, e);
				end
			join
			repeat (10) @(posedge clk);
			apb_xfer(k[0] ? IDX_CLK_LANE : IDX_LANE3, 1'b0, 32'h0, d2, e);
			check(d1 | d2, k[0] ? 32'h8 : 32'h10, "set under read");
			rd_chk(k[0] ? IDX_LANE3 : IDX_CLK_LANE, k[0] ? 32'h10 : 32'h8, "other flag");
		end
	endtask

	initial begin
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		t_reset();
		t_flags(IDX_LANE3, 4, 1'b0);
		t_flags(IDX_CLK_LANE, 3, 1'b1);
		t_sync();
		t_timeout();
		t_race();
		test_done();
	end
endmodule
